// ---- clk_mode_pkg.sv ----
// Constants and types shared by the clock-mode and stop controller.
package clk_mode_pkg;

	// ------------------------------------------------------------
	// Register bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_RST_FLAGS = 8'h03;
	localparam logic [7:0] OFS_SYNTH     = 8'h04;
	localparam logic [7:0] OFS_REF_DIV   = 8'h05;
	localparam logic [7:0] OFS_POST_DIV  = 8'h06;
	localparam logic [7:0] OFS_PLL_STAT  = 8'h07;
	localparam logic [7:0] OFS_CLK_SEL   = 8'h09;
	localparam logic [7:0] OFS_WDOG_CTL  = 8'h0c;
	localparam logic [7:0] OFS_PER_CTL   = 8'h12;
	localparam logic [7:0] OFS_OSC_CTL   = 8'h1a;
	localparam logic [7:0] OFS_MODE_STAT = 8'h1d;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RF_POR  = 6;
	localparam int RF_LVR  = 5;
	localparam int RF_WDOG = 3;
	localparam int RF_OMON = 1;
	localparam int RF_PMON = 0;
	localparam int PS_LOCK = 3;
	localparam int PS_UP   = 0;
	localparam int CS_PLL  = 7;
	localparam int CS_PSEUDO_STOP_SELECT = 6;
	localparam int CS_GATE = 5;
	localparam int CS_WDHI = 4;
	localparam int CS_RPSE = 3;
	localparam int CS_WPSE = 2;
	localparam int CS_RTI  = 1;
	localparam int CS_WDLO = 0;
	localparam int WC_HALT = 6;
	localparam int PC_SRC  = 4;
	localparam int PC_EN   = 3;
	localparam int OC_EN   = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SYNTH    = 8'h00;
	localparam logic [3:0] RST_REF_DIV  = 4'h0;
	localparam logic [4:0] RST_POST_DIV = 5'h03;
	localparam logic [7:0] RST_CLK_SEL  = 8'h80;
	localparam logic [7:0] RST_WDOG_CTL = 8'h00;
	localparam logic [7:0] RST_FLAGS    = 8'h40;
	localparam logic [2:0] WDOG_RATE_MAX = 3'h7;

	// ------------------------------------------------------------
	// Frequencies after reset and timing counts
	// ------------------------------------------------------------
	localparam int VCO_RESET_KHZ = 50000;
	localparam int BUS_DIV_PLL   = 2;
	localparam int BUS_RESET_KHZ =
		VCO_RESET_KHZ / (int'(RST_POST_DIV) + 1) / BUS_DIV_PLL;
	localparam logic [4:0] RST_STRETCH_CYC = 5'h10;
	localparam int N_RST_SRC = 4;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_FULL   = 2'b01,
		ST_PSEUDO = 2'b10
	} stop_state_e;

	typedef enum logic [1:0] {
		MODE_PLL_INT = 2'b00,
		MODE_PLL_XTL = 2'b01,
		MODE_BYPASS  = 2'b10
	} clk_mode_e;

	localparam logic [1:0] TSRC_IRC  = 2'b00;
	localparam logic [1:0] TSRC_CRYSTAL_OUT_PIN = 2'b01;
	localparam logic [1:0] TSRC_ACLK = 2'b10;

endpackage

// ---- clk_mode_ctrl.sv ----
// Clock-mode, stop-mode and reset-pin controller of the power unit.
//
// Operation
// RQ1 - After any reset, bus runs from PLL referenced to internal RC.
// RQ2 - Reset PLL setting: 50 MHz VCO, post divider 3, bus 6.25 MHz.
// RQ3 - Software configures PLL, enables oscillator, waits up and lock flags.
// RQ4 - Bypass mode: bus from crystal, PLL keeps running to qualify it.
// RQ5 - Software enables oscillator, waits up flag, then clears PLL select.
// RQ6 - Wait mode behaves exactly like run mode.
// RQ7 - Stop: reduced regulator, PLL and RC off, core and bus halted.
// RQ8 - Stop keeps only always-on clock; low-voltage monitors are off. Pseudo stop here also keeps the crystal running.
// RQ9 - Pseudo stop only when pseudo select and oscillator enable are set.
// RQ10 - Full stop disables the crystal oscillator.
// RQ11 - Pseudo stop keeps the crystal oscillator running.
// RQ12 - Full stop with low watchdog source halts watchdog and periodic timer.
// RQ13 - Full-stop wake restores PLL select, RC sources for both timers.
// RQ14 - High watchdog source uses always-on clock, gated in stop by gate bit.
// RQ15 - Full stop halts periodic timer; afterwards watchdog stays on always-on.
// RQ16 - Pseudo stop keeps timers on crystal clock when their enables set.
// RQ17 - Pseudo stop entry and exit leave clock select bits untouched.
// RQ18 - Pseudo stop, high source: timer on crystal, watchdog follows gate.
// RQ19 - Software waits oscillator start-up time before entering pseudo stop.
// RQ20 - Debug freeze: timers may halt, watchdog forced to longest timeout.
// RQ21 - Reset pin active low both ways; open-drain low marks internal reset.
// RQ22 - Clock output pin carries selected source only while enabled.
// RQ23 - System reset from power-on, low voltage, watchdog, monitors, pin.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module clk_mode_ctrl #(
	parameter logic [4:0] RST_HOLD = clk_mode_pkg::RST_STRETCH_CYC
) (
	// Clock and resets
	input  wire logic                             MCLK,
	input  wire logic                             RST,
	input  wire logic                             RESET_PIN_N_IN,
	output logic                                  RESET_PIN_OUT,
	output logic                                  RESET_PIN_OE,
	output logic                                  SYS_RESET,
	// Register port
	input  wire logic [clk_mode_pkg::ADDR_W-1:0]  ADDR,
	input  wire logic [clk_mode_pkg::DATA_W-1:0]  WDATA,
	input  wire logic                             WR,
	input  wire logic                             RD,
	output logic      [clk_mode_pkg::DATA_W-1:0]  RDATA,
	// Core requests
	input  wire logic                             STOP_REQ,
	input  wire logic                             WAKE_REQ,
	input  wire logic                             DEBUG_ACTIVE,
	// Analog status and reset sources
	input  wire logic                             OSC_UP,
	input  wire logic                             PLL_LOCK,
	input  wire logic                             LV_DETECT,
	input  wire logic                             WDOG_TIMEOUT,
	input  wire logic                             OSC_MON_FAIL,
	input  wire logic                             PLL_MON_FAIL,
	// Periodic clock output sources
	input  wire logic                             ALWAYS_ON_CLK,
	input  wire logic                             PERIODIC_TICK,
	// Clock tree and analog controls
	output logic                                  BUS_FROM_PLL,
	output logic                                  PLL_REF_CRYSTAL,
	output logic      [1:0]                       CLK_MODE,
	output logic                                  PLL_EN,
	output logic                                  IRC_EN,
	output logic                                  OSC_EN,
	output logic                                  REG_REDUCED,
	output logic                                  CORE_CLK_RUN,
	output logic                                  LV_MON_EN,
	output logic      [7:0]                       SYNTH_DIV,
	output logic      [3:0]                       REF_DIV,
	output logic      [4:0]                       POST_DIV,
	// Watchdog and periodic timer clocking
	output logic      [1:0]                       WDOG_CLK_SRC,
	output logic                                  WDOG_CLK_RUN,
	output logic      [2:0]                       WDOG_RATE,
	output logic      [1:0]                       RTI_CLK_SRC,
	output logic                                  RTI_CLK_RUN,
	// Periodic clock output pin
	output logic                                  PCLK_OUT,
	output logic                                  PCLK_OE
);
	import clk_mode_pkg::*;

	// ------------------------------------------------------------
	// Reset tree
	// ------------------------------------------------------------
	// RQ21 pin reset asynchronous
	// A low pin joins the asynchronous reset so the whole unit clears
	// without waiting for a clock edge.
	wire logic arst = RST | ~RESET_PIN_N_IN;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int N_SYNC = 8;
	wire logic [N_SYNC-1:0] async_in = {ALWAYS_ON_CLK, PLL_MON_FAIL,
		OSC_MON_FAIL, WDOG_TIMEOUT, LV_DETECT, PLL_LOCK, OSC_UP,
		DEBUG_ACTIVE};
	logic [N_SYNC-1:0] meta_ff;
	logic [N_SYNC-1:0] sync_ff;

	// Two stages per input; only the second stage is read by logic.
	genvar gi;
	generate
		for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
			always_ff @(posedge MCLK or posedge arst) begin
				if (arst) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= async_in[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate

	wire logic dbg_s   = sync_ff[0];
	wire logic up_s    = sync_ff[1];
	wire logic lock_s  = sync_ff[2];
	wire logic aclk_s  = sync_ff[7];
	wire logic [N_RST_SRC-1:0] rsrc_s = sync_ff[6:3];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]  synth_ff;
	logic [3:0]  reference_divider_ff;
	logic [4:0]  postdiv_ff;
	logic [7:0]  clksel_ff;
	logic [7:0]  wdctl_ff;
	logic        per_src_ff;
	logic        per_en_ff;
	logic        osc_en_ff;
	logic [7:0]  flags_ff;
	logic [4:0]  hold_ff;
	stop_state_e state_ff;
	stop_state_e nxt_state;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	wire logic stopped  = (state_ff != ST_RUN);
	wire logic in_full  = (state_ff == ST_FULL);
	wire logic in_pseu  = (state_ff == ST_PSEUDO);
	wire logic wr_ok    = WR & ~stopped & ~SYS_RESET;
	wire logic wr_synth = wr_ok & hit(ADDR, OFS_SYNTH);
	wire logic wr_ref   = wr_ok & hit(ADDR, OFS_REF_DIV);
	wire logic wr_post  = wr_ok & hit(ADDR, OFS_POST_DIV);
	wire logic wr_clks  = wr_ok & hit(ADDR, OFS_CLK_SEL);
	wire logic wr_wdog  = wr_ok & hit(ADDR, OFS_WDOG_CTL);
	wire logic wr_per   = wr_ok & hit(ADDR, OFS_PER_CTL);
	wire logic wr_osc   = wr_ok & hit(ADDR, OFS_OSC_CTL);
	wire logic wr_flags = WR & hit(ADDR, OFS_RST_FLAGS);

	// ------------------------------------------------------------
	// Stop sequencer
	// ------------------------------------------------------------
	// RQ9 full or pseudo choice
	// The stop flavour is fixed at entry; the oscillator cannot change
	// while stopped because the bus is halted.
	wire logic pseudo_ok = clksel_ff[CS_PSEUDO_STOP_SELECT] & osc_en_ff;

	// RQ6 wait equals run
	// Wait has no input here: only the stop request leaves run.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (STOP_REQ) begin
					nxt_state = pseudo_ok ? ST_PSEUDO : ST_FULL;
				end
			end
			ST_FULL, ST_PSEUDO: begin
				if (WAKE_REQ) begin
					nxt_state = ST_RUN;
				end
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	wire logic full_exit = in_full & WAKE_REQ;

	// ------------------------------------------------------------
	// Internal reset generation
	// ------------------------------------------------------------
	// RQ23 reset sources
	// Low-voltage detection counts only while the monitors are powered.
	wire logic [N_RST_SRC-1:0] rsrc_q = {rsrc_s[3:1],
		rsrc_s[0] & ~stopped};
	wire logic int_rst_req = |rsrc_q;

	// Hold counter stretches a reset request so the pin pulse is long.
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			hold_ff <= 5'h00;
		end else if (int_rst_req) begin
			hold_ff <= RST_HOLD;
		end else if (hold_ff != 5'h00) begin
			hold_ff <= hold_ff - 5'h01;
		end
	end

	// RQ21 open-drain reset indication
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			SYS_RESET    <= 1'b1;
			RESET_PIN_OE <= 1'b1;
		end else begin
			SYS_RESET    <= int_rst_req | (hold_ff != 5'h00);
			RESET_PIN_OE <= int_rst_req | (hold_ff != 5'h00);
		end
	end

	// Open-drain: the pin only ever drives low.
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			RESET_PIN_OUT <= 1'b0;
		end else begin
			RESET_PIN_OUT <= 1'b0;
		end
	end

	// Reset cause flags; a new cause wins over a write-one clear.
	wire logic [7:0] flag_set = {1'b0, 1'b0, rsrc_q[0], 1'b0,
		rsrc_q[1], 1'b0, rsrc_q[2], rsrc_q[3]};
	wire logic [7:0] flag_clr = wr_flags ? WDATA : 8'h00;
	wire logic [7:0] flag_msk = 8'h6b;

	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			flags_ff <= RST_FLAGS;
		end else begin
			flags_ff <= ((flags_ff & ~flag_clr) | flag_set) & flag_msk;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// RQ1 RQ2 reset configuration
	// An internal reset returns every setting to the default engaged mode.
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			synth_ff   <= RST_SYNTH;
			reference_divider_ff  <= RST_REF_DIV;
			postdiv_ff <= RST_POST_DIV;
			osc_en_ff  <= 1'b0;
			wdctl_ff   <= RST_WDOG_CTL;
			per_src_ff <= 1'b0;
			per_en_ff  <= 1'b0;
		end else if (SYS_RESET) begin
			synth_ff   <= RST_SYNTH;
			reference_divider_ff  <= RST_REF_DIV;
			postdiv_ff <= RST_POST_DIV;
			osc_en_ff  <= 1'b0;
			wdctl_ff   <= RST_WDOG_CTL;
			per_src_ff <= 1'b0;
			per_en_ff  <= 1'b0;
		end else begin
			if (wr_synth) begin
				synth_ff <= WDATA;
			end
			if (wr_ref) begin
				reference_divider_ff <= WDATA[3:0];
			end
			if (wr_post) begin
				postdiv_ff <= WDATA[4:0];
			end
			if (wr_osc) begin
				osc_en_ff <= WDATA[OC_EN];
			end
			if (wr_wdog) begin
				wdctl_ff <= WDATA & 8'h47;
			end
			if (wr_per) begin
				per_src_ff <= WDATA[PC_SRC];
				per_en_ff  <= WDATA[PC_EN];
			end
		end
	end

	// Clock select register and stop sequencer state.
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			clksel_ff <= RST_CLK_SEL;
			state_ff  <= ST_RUN;
		end else if (SYS_RESET) begin
			clksel_ff <= RST_CLK_SEL;
			state_ff  <= ST_RUN;
		end else begin
			state_ff <= nxt_state;
			// RQ13 full-stop wake restore
			if (full_exit) begin
				clksel_ff[CS_PLL]  <= 1'b1;
				clksel_ff[CS_WDLO] <= 1'b0;
				clksel_ff[CS_RTI]  <= 1'b0;
			// RQ17 pseudo stop keeps selects
			end else if (wr_clks) begin
				clksel_ff <= WDATA;
			end
		end
	end

	// ------------------------------------------------------------
	// Timer clock steering
	// ------------------------------------------------------------
	wire logic wd_hi    = clksel_ff[CS_WDHI];
	wire logic wd_gate  = clksel_ff[CS_GATE];
	wire logic dbg_halt = dbg_s & wdctl_ff[WC_HALT];

	// RQ12 RQ14 RQ16 RQ18 watchdog clock
	// The gate bit only matters while stopped on the always-on clock.
	wire logic wd_run_n =
		in_full ? (wd_hi & ~wd_gate) :
		in_pseu ? (wd_hi ? ~wd_gate : clksel_ff[CS_WPSE]) :
		~dbg_halt;

	// RQ15 RQ16 RQ18 periodic timer clock
	wire logic rti_run_n =
		in_full ? 1'b0 :
		in_pseu ? clksel_ff[CS_RPSE] :
		~dbg_halt;

	// In pseudo stop the RC clock is off, so a running timer without
	// the always-on source must fall back to the crystal.
	wire logic [1:0] wd_src_n =
		wd_hi ? TSRC_ACLK :
		(in_pseu | clksel_ff[CS_WDLO]) ? TSRC_CRYSTAL_OUT_PIN : TSRC_IRC;
	wire logic [1:0] rti_src_n =
		(in_pseu | clksel_ff[CS_RTI]) ? TSRC_CRYSTAL_OUT_PIN : TSRC_IRC;

	// RQ20 freeze forces longest timeout
	// Forcing applies only to an armed watchdog; a zero rate stays off.
	wire logic [2:0] rate_n = (dbg_s & (wdctl_ff[2:0] != 3'h0)) ?
		WDOG_RATE_MAX : wdctl_ff[2:0];

	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			WDOG_CLK_RUN <= 1'b1;
			RTI_CLK_RUN  <= 1'b1;
			WDOG_CLK_SRC <= TSRC_IRC;
			RTI_CLK_SRC  <= TSRC_IRC;
			WDOG_RATE    <= 3'h0;
		end else begin
			WDOG_CLK_RUN <= wd_run_n;
			RTI_CLK_RUN  <= rti_run_n;
			WDOG_CLK_SRC <= wd_src_n;
			RTI_CLK_SRC  <= rti_src_n;
			WDOG_RATE    <= rate_n;
		end
	end

	// ------------------------------------------------------------
	// Clock tree and power controls
	// ------------------------------------------------------------
	// RQ1 RQ4 clock mode
	// The PLL stays on in bypass so it can qualify the crystal clock.
	wire logic [1:0] mode_n = ~clksel_ff[CS_PLL] ? MODE_BYPASS :
		osc_en_ff ? MODE_PLL_XTL : MODE_PLL_INT;

	// RQ7 RQ8 RQ10 RQ11 stop power state
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			BUS_FROM_PLL    <= 1'b1;
			PLL_REF_CRYSTAL <= 1'b0;
			CLK_MODE        <= MODE_PLL_INT;
			PLL_EN          <= 1'b1;
			IRC_EN          <= 1'b1;
			OSC_EN          <= 1'b0;
			REG_REDUCED     <= 1'b0;
			CORE_CLK_RUN    <= 1'b1;
			LV_MON_EN       <= 1'b1;
		end else begin
			BUS_FROM_PLL    <= clksel_ff[CS_PLL];
			PLL_REF_CRYSTAL <= osc_en_ff;
			CLK_MODE        <= mode_n;
			PLL_EN          <= ~stopped;
			IRC_EN          <= ~stopped;
			OSC_EN          <= osc_en_ff & ~in_full;
			REG_REDUCED     <= stopped;
			CORE_CLK_RUN    <= ~stopped;
			LV_MON_EN       <= ~stopped;
		end
	end

	// RQ2 divider outputs
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			SYNTH_DIV <= RST_SYNTH;
			REF_DIV   <= RST_REF_DIV;
			POST_DIV  <= RST_POST_DIV;
		end else begin
			SYNTH_DIV <= synth_ff;
			REF_DIV   <= reference_divider_ff;
			POST_DIV  <= postdiv_ff;
		end
	end

	// ------------------------------------------------------------
	// Periodic clock output pin
	// ------------------------------------------------------------
	// RQ22 source select and enable
	// The pin is only driven while enabled, so it floats otherwise.
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			PCLK_OUT <= 1'b0;
			PCLK_OE  <= 1'b0;
		end else begin
			PCLK_OUT <= per_en_ff & (per_src_ff ? aclk_s : PERIODIC_TICK);
			PCLK_OE  <= per_en_ff;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// RQ3 RQ5 RQ19 software polls status
	// Up and lock flags let software sequence mode changes safely.
	wire logic [7:0] pll_stat = {4'h0, lock_s, 2'b00, up_s};
	wire logic [7:0] mode_st  = {4'h0, CLK_MODE, state_ff};

	logic [7:0] rd_mux;
	always_comb begin
		case (ADDR)
			OFS_RST_FLAGS: rd_mux = flags_ff;
			OFS_SYNTH:     rd_mux = synth_ff;
			OFS_REF_DIV:   rd_mux = {4'h0, reference_divider_ff};
			OFS_POST_DIV:  rd_mux = {3'h0, postdiv_ff};
			OFS_PLL_STAT:  rd_mux = pll_stat;
			OFS_CLK_SEL:   rd_mux = clksel_ff;
			OFS_WDOG_CTL:  rd_mux = wdctl_ff;
			OFS_PER_CTL:   rd_mux = {3'h0, per_src_ff, per_en_ff, 3'h0};
			OFS_OSC_CTL:   rd_mux = {osc_en_ff, 7'h00};
			OFS_MODE_STAT: rd_mux = mode_st;
			default:       rd_mux = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge MCLK or posedge arst) begin
		if (arst) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= RD ? rd_mux : 8'h00;
		end
	end

endmodule

// ---- clk_osc_model.sv ----
// Far-side model: crystal start-up, PLL lock and always-on clock.
`timescale 1ns/1ps
module clk_osc_model #(
	parameter int UP_CYC = 12
) (
	// Controls from the unit
	input  wire logic clk,
	input  wire logic osc_en,
	input  wire logic pll_en,
	// Status back to the unit
	output logic      osc_up,
	output logic      pll_lock,
	output logic      aclk
);
	int up_cnt = 0;
	int lk_cnt = 0;

	// start-up and lock
	// A stopped crystal drops its up flag at once, so software must wait.
	always @(posedge clk) begin
		up_cnt <= osc_en ? up_cnt + 1 : 0;
		lk_cnt <= pll_en ? lk_cnt + 1 : 0;
	end
	assign osc_up = (up_cnt > UP_CYC);
	assign pll_lock = (lk_cnt > 4);

	// Always-on clock, unrelated in phase to the bus clock.
	initial begin
		aclk = 1'b0;
		forever #37 aclk = ~aclk;
	end
endmodule

// ---- clk_mode_ctrl_checker.sv ----
// Port assertions for the clock-mode and stop controller.
`timescale 1ns/1ps
module clk_mode_checker
	import clk_mode_pkg::*;
(
	// Clock, resets and requests
	input wire logic       MCLK,
	input wire logic       RST,
	input wire logic       RESET_PIN_N_IN,
	input wire logic       RESET_PIN_OUT,
	input wire logic       RESET_PIN_OE,
	input wire logic       SYS_RESET,
	input wire logic       STOP_REQ,
	input wire logic       WAKE_REQ,
	input wire logic       WDOG_TIMEOUT,
	// Clock tree and pins
	input wire logic       BUS_FROM_PLL,
	input wire logic       PLL_REF_CRYSTAL,
	input wire logic [1:0] CLK_MODE,
	input wire logic       PLL_EN,
	input wire logic       OSC_EN,
	input wire logic       REG_REDUCED,
	input wire logic       CORE_CLK_RUN,
	input wire logic       LV_MON_EN,
	input wire logic [4:0] POST_DIV,
	input wire logic [1:0] RTI_CLK_SRC,
	input wire logic       RTI_CLK_RUN,
	input wire logic       PCLK_OUT,
	input wire logic       PCLK_OE
);
	// ------------------------------------------------------------
	// Sequences and assertions
	// ------------------------------------------------------------
	// Internal reset also returns the mode state, so it masks the checks.
	default clocking dc @(posedge MCLK); endclocking
	default disable iff (RST || !RESET_PIN_N_IN || SYS_RESET);
	sequence stop_taken;
		STOP_REQ && CORE_CLK_RUN;
	endsequence
	sequence stopped_outs;
		!PLL_EN && !CORE_CLK_RUN && REG_REDUCED && !LV_MON_EN;
	endsequence

	a_pin_follows_reset: assert property (
		disable iff (RST || !RESET_PIN_N_IN)
		RESET_PIN_OE == SYS_RESET && !RESET_PIN_OUT)
		else $error("reset pin drive wrong");
	a_boot_defaults: assert property (
		$fell(SYS_RESET) |-> CLK_MODE == MODE_PLL_INT && BUS_FROM_PLL
		&& POST_DIV == RST_POST_DIV)
		else $error("boot clock setting wrong");
	a_stop_halts: assert property (stop_taken |-> ##2 stopped_outs)
		else $error("stop did not halt clocks");
	a_full_no_osc: assert property (
		stop_taken and !PLL_REF_CRYSTAL |-> ##2 !OSC_EN)
		else $error("oscillator kept in full stop");
	a_full_rti_halt: assert property (
		(!CORE_CLK_RUN && !OSC_EN)[*2] |-> !RTI_CLK_RUN)
		else $error("periodic timer runs in full stop");
	a_wake_restores: assert property (
		WAKE_REQ && !CORE_CLK_RUN && !OSC_EN |->
		##2 BUS_FROM_PLL && RTI_CLK_SRC == TSRC_IRC)
		else $error("full stop wake left clock select");
	a_pseudo_keeps_sel: assert property (
		WAKE_REQ && !CORE_CLK_RUN && OSC_EN |->
		##2 BUS_FROM_PLL == $past(BUS_FROM_PLL, 2))
		else $error("pseudo stop changed bus source");
	a_bypass_mode: assert property (
		!BUS_FROM_PLL && CORE_CLK_RUN |-> CLK_MODE == MODE_BYPASS && PLL_EN)
		else $error("bypass mode state wrong");
	a_pin_gated: assert property (!PCLK_OE |-> !PCLK_OUT)
		else $error("clock pin active while disabled");
	a_cause_resets: assert property (
		disable iff (RST || !RESET_PIN_N_IN)
		$rose(WDOG_TIMEOUT) && !SYS_RESET |-> ##[1:4] SYS_RESET)
		else $error("timeout raised no reset");
endmodule

bind clk_mode_ctrl clk_mode_checker clk_mode_checker_inst (
	.MCLK(MCLK), .RST(RST), .RESET_PIN_N_IN(RESET_PIN_N_IN),
	.RESET_PIN_OUT(RESET_PIN_OUT), .RESET_PIN_OE(RESET_PIN_OE),
	.SYS_RESET(SYS_RESET), .STOP_REQ(STOP_REQ), .WAKE_REQ(WAKE_REQ),
	.WDOG_TIMEOUT(WDOG_TIMEOUT), .BUS_FROM_PLL(BUS_FROM_PLL),
	.PLL_REF_CRYSTAL(PLL_REF_CRYSTAL), .CLK_MODE(CLK_MODE),
	.PLL_EN(PLL_EN), .OSC_EN(OSC_EN), .REG_REDUCED(REG_REDUCED),
	.CORE_CLK_RUN(CORE_CLK_RUN), .LV_MON_EN(LV_MON_EN),
	.POST_DIV(POST_DIV), .RTI_CLK_SRC(RTI_CLK_SRC),
	.RTI_CLK_RUN(RTI_CLK_RUN), .PCLK_OUT(PCLK_OUT), .PCLK_OE(PCLK_OE));

// ---- clock_mode_stop_control_tb.sv ----
// Self-checking bench for the clock-mode and stop controller.
`timescale 1ns/1ps
module clock_mode_stop_control_tb;
	import clk_mode_pkg::*;
	// ------------------------------------------------------------
	// Signals and case tables
	// ------------------------------------------------------------
	logic       MCLK, RST, RESET_PIN_N_IN, RESET_PIN_OUT, RESET_PIN_OE;
	logic       SYS_RESET, WR, RD, STOP_REQ, WAKE_REQ, DEBUG_ACTIVE;
	logic       OSC_UP, PLL_LOCK, ALWAYS_ON_CLK, PERIODIC_TICK, IRC_EN;
	logic       BUS_FROM_PLL, PLL_REF_CRYSTAL, PLL_EN, OSC_EN, LV_MON_EN;
	logic       REG_REDUCED, CORE_CLK_RUN, WDOG_CLK_RUN, RTI_CLK_RUN;
	logic       PCLK_OUT, PCLK_OE;
	logic [1:0] CLK_MODE, WDOG_CLK_SRC, RTI_CLK_SRC;
	logic [2:0] WDOG_RATE;
	logic [3:0] REF_DIV, cause;
	logic [4:0] POST_DIV;
	logic [7:0] ADDR, WDATA, RDATA, SYNTH_DIV;
	int         bad_count = 0;
	int         samples_checked = 0;
	// Register rows: offset, write value, read-back value.
	logic [7:0] regs [7][3] = '{'{OFS_SYNTH, 8'h5a, 8'h5a},
		'{OFS_REF_DIV, 8'hfa, 8'h0a}, '{OFS_POST_DIV, 8'hff, 8'h1f},
		'{OFS_WDOG_CTL, 8'hff, 8'h47}, '{OFS_PER_CTL, 8'hff, 8'h18},
		'{OFS_PLL_STAT, 8'hff, 8'h08}, '{8'h20, 8'hff, 8'h00}};
	// Stop rows: select, osc, stop outputs, mode status, select after.
	logic [7:0] stops [7][5] = '{'{8'h8c, 8'h80, 8'h10, 8'h05, 8'h8c},
		'{8'h4c, 8'h80, 8'h17, 8'h0a, 8'h4c},
		'{8'h70, 8'h80, 8'h14, 8'h0a, 8'h70},
		'{8'hc8, 8'h80, 8'h15, 8'h06, 8'hc8},
		'{8'hcf, 8'h00, 8'h10, 8'h01, 8'hcc},
		'{8'h90, 8'h00, 8'h12, 8'h01, 8'h90},
		'{8'hb0, 8'h00, 8'h10, 8'h01, 8'hb0}};
	logic [7:0] flag [4] = '{8'h01, 8'h02, 8'h08, 8'h20};

	clk_mode_ctrl #(.RST_HOLD(5'h02)) clk_mode_ctrl_inst (
		.LV_DETECT(cause[3]), .WDOG_TIMEOUT(cause[2]),
		.OSC_MON_FAIL(cause[1]), .PLL_MON_FAIL(cause[0]), .*);
	clk_osc_model clk_osc_model_inst (.clk(MCLK), .osc_en(OSC_EN),
		.pll_en(PLL_EN), .osc_up(OSC_UP), .pll_lock(PLL_LOCK),
		.aclk(ALWAYS_ON_CLK));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge MCLK);
		@(negedge MCLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		@(negedge MCLK);
		chk(RDATA, e);
	endtask
	task automatic step(input logic s);
		@(posedge MCLK);
		STOP_REQ <= s;
		WAKE_REQ <= !s;
		@(posedge MCLK);
		{STOP_REQ, WAKE_REQ} <= 2'b00;
		settle(2);
	endtask
	task automatic wait_up();
		for (int k = 0; k < 200 && !(OSC_UP && PLL_LOCK); k++)
			@(posedge MCLK);
		repeat (4) @(posedge MCLK);
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end
	// The run needs under 400 cycles; this limit of 10000 cycles is over twenty-five times that.
	initial begin
		#500us;
		bad_count++;
		summarize();
	end
	initial begin
		{RST, RESET_PIN_N_IN, WR, RD, STOP_REQ, WAKE_REQ} = 6'b110000;
		{DEBUG_ACTIVE, PERIODIC_TICK, cause, ADDR, WDATA} = '0;
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		settle(2);
		chk({CLK_MODE, POST_DIV, BUS_FROM_PLL}, 8'h07);
		rd(OFS_CLK_SEL, RST_CLK_SEL);
		for (int i = 0; i < 7; i++) begin
			wr(regs[i][0], regs[i][1]);
			rd(regs[i][0], regs[i][2]);
		end
		// Oscillator waits precede every crystal or pseudo stop use.
		for (int i = 0; i < 7; i++) begin
			wr(OFS_OSC_CTL, stops[i][1]);
			if (stops[i][1][7]) begin
				wait_up();
				rd(OFS_PLL_STAT, 8'h09);
			end
			wr(OFS_CLK_SEL, stops[i][0]);
			step(1'b1);
			chk({PLL_EN, IRC_EN, CORE_CLK_RUN, REG_REDUCED, LV_MON_EN,
				OSC_EN, WDOG_CLK_RUN, RTI_CLK_RUN}, stops[i][2]); // 18
			rd(OFS_MODE_STAT, stops[i][3]);
			step(1'b0);
			rd(OFS_CLK_SEL, stops[i][4]);
		end
		wr(OFS_WDOG_CTL, 8'h43);
		DEBUG_ACTIVE <= 1'b1;
		settle(5);
		chk({3'h0, WDOG_RATE, WDOG_CLK_RUN, RTI_CLK_RUN}, 8'h1c);
		@(posedge MCLK);
		DEBUG_ACTIVE <= 1'b0;
		settle(5);
		chk({3'h0, WDOG_RATE, WDOG_CLK_RUN, RTI_CLK_RUN}, 8'h0f);
		wr(OFS_PER_CTL, 8'h08);
		PERIODIC_TICK <= 1'b1;
		settle(3);
		chk({6'h00, PCLK_OE, PCLK_OUT}, 8'h03);
		wr(OFS_PER_CTL, 8'h00);
		settle(3);
		chk({6'h00, PCLK_OE, PCLK_OUT}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_RST_FLAGS, 8'hff);
			cause <= 4'(1 << i);
			repeat (2) @(posedge MCLK);
			cause <= 4'h0;
			settle(2);
			chk({6'h00, SYS_RESET, RESET_PIN_OE}, 8'h03);
			for (int k = 0; k < 50 && SYS_RESET !== 1'b0; k++)
				@(posedge MCLK);
			rd(OFS_RST_FLAGS, flag[i]);
		end
		@(posedge MCLK);
		RESET_PIN_N_IN <= 1'b0;
		@(negedge MCLK);
		chk({6'h00, SYS_RESET, RESET_PIN_OE}, 8'h03);
		@(posedge MCLK);
		RESET_PIN_N_IN <= 1'b1;
		settle(3);
		summarize();
	end
endmodule
